// ===== shared/udi_map.svh
// register map, field positions, reset values and timing of the dma/irq block
// assumes a 32-bit axi4-lite bus with byte addresses in the low 8 bits
`ifndef UDI_MAP_SVH
`define UDI_MAP_SVH
`define UDI_A_HW      8'h00
`define UDI_A_START   8'h04
`define UDI_A_CFG     8'h08
`define UDI_A_LEN     8'h0C
`define UDI_A_STAT    8'h10
`define UDI_A_IEN     8'h14
`define UDI_A_EDGE    8'h18
`define UDI_A_ORM0    8'h20
`define UDI_A_ORM1    8'h24
`define UDI_A_ORM2    8'h28
`define UDI_A_ANDM0   8'h30
`define UDI_A_ANDM1   8'h34
`define UDI_A_ANDM2   8'h38
`define UDI_A_ATLTO   8'h3C
`define UDI_A_CUR     8'h40
`define UDI_B_GATE    0
`define UDI_B_TRIG    1
`define UDI_B_POL     2
`define UDI_B_REQHI   5
`define UDI_B_GNTHI   6
`define UDI_B_BUS32   8
`define UDI_B_GO      1
`define UDI_B_BURST   8
`define UDI_B_DMADONE 3
`define UDI_B_CAT0    7
`define UDI_B_GAP     24
`define UDI_CLK_NS    100
`define UDI_PW_DEF_NS 500
`define UDI_PW_DEF_CYC ((`UDI_PW_DEF_NS + `UDI_CLK_NS - 1) / `UDI_CLK_NS)
`define UDI_PW_MUL    5
`define UDI_PW_SHIFT  5
`define UDI_GAP_SHIFT 8
`define UDI_EDGE_RST  (32'((`UDI_PW_DEF_CYC << `UDI_PW_SHIFT) / `UDI_PW_MUL))
`define UDI_RESP_OK   2'b00
`define UDI_RESP_ERR  2'b10
`endif

// ===== shared/udi_pkg.sv
// types of the dma/irq block
// assumes udi_map.svh for all numeric constants
package udi_pkg;
    typedef enum logic [1:0] {
        UDI_IDLE = 2'b00,
        UDI_REQ  = 2'b01,
        UDI_HOLD = 2'b10
    } udi_dma_e;
    typedef struct packed {
        logic        edge_mode;
        logic        pol_high;
        logic [15:0] pw_field;
        logic [7:0]  gap_field;
    } udi_shape_cfg_s;
    typedef struct packed {
        logic        act;
        logic        prev;
        logic        pend;
        logic [15:0] pcnt;
        logic [15:0] gcnt;
        logic        pin;
    } udi_shape_s;
    typedef struct packed {
        udi_dma_e         dma;
        logic [15:0]      addr;
        logic [16:0]      remain;
        logic [7:0]       bcnt;
        logic [31:0]      hw;
        logic [31:0]      start;
        logic [31:0]      cfg;
        logic [31:0]      len;
        logic [31:0]      status;
        logic [31:0]      ien;
        logic [31:0]      edge_sh;
        logic [2:0][31:0] orm;
        logic [2:0][31:0] andm;
        logic [15:0]      atl_to;
        logic [15:0]      tmr;
        logic             atl_pend;
        logic [2:0]       cond_q;
        logic             req_pin;
        logic [15:0]      maddr;
        logic             mwe;
        logic             mre;
        logic [3:0]       mbe;
        logic             aw_got;
        logic             w_got;
        logic [7:0]       awaddr;
        logic [31:0]      wdata;
        logic [3:0]       wstrb;
        logic             awready;
        logic             wready;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             arready;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
    } udi_core_s;
endpackage

// ===== hdl/udi_irq_shaper.sv
// interrupt pin shaper: level or fixed pulse, minimum gap, polarity
// assumes want is a registered level from the status logic
`include "udi_map.svh"
module udi_irq_shaper
    import udi_pkg::*;
(
    // clock and reset
    input  wire logic           clk,
    input  wire logic           rst,
    // control
    input  wire udi_shape_cfg_s cfg,
    input  wire logic           want,
    // pin
    output logic                irq_pin
);
    udi_shape_s s;
    udi_shape_s next_s;
    logic [15:0] pw_cyc;
    logic [15:0] gap_cyc;
    logic        start;
    ////////////////////////////////////////////////////////////////////////
    assign pw_cyc  = 16'((32'(cfg.pw_field) * `UDI_PW_MUL) >> `UDI_PW_SHIFT);
    assign gap_cyc = 16'({cfg.gap_field, 8'h00} >> (8 - `UDI_GAP_SHIFT));
    assign start   = cfg.edge_mode && s.pcnt == 16'h0 && s.gcnt == 16'h0
                     && (s.pend || (want && !s.prev));
    always_comb begin
        next_s = s;
        next_s.prev = want;
        if (!cfg.edge_mode) begin
            next_s.act  = want;
            next_s.pend = 1'b0;
            next_s.pcnt = 16'h0;
            next_s.gcnt = 16'h0;
        end else if (start) begin
            next_s.act  = 1'b1;
            next_s.pend = 1'b0;
            next_s.pcnt = (pw_cyc == 16'h0) ? 16'h1 : pw_cyc;
        end else begin
            next_s.pend = s.pend || (want && !s.prev);
            if (s.pcnt != 16'h0) begin
                next_s.pcnt = s.pcnt - 16'h1;
                if (s.pcnt == 16'h1) begin
                    next_s.act  = 1'b0;
                    next_s.gcnt = gap_cyc;
                end
            end else if (s.gcnt != 16'h0) begin
                next_s.gcnt = s.gcnt - 16'h1;
            end
        end
        next_s.pin = next_s.act ~^ cfg.pol_high;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            s     <= '0;
            s.pin <= 1'b1;
        end else begin
            s <= next_s;
        end
    end
    assign irq_pin = s.pin;
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_pulse_holds: assert property (cfg.edge_mode && s.pcnt > 16'h1 && $stable(cfg) |=> s.act)
        else $error("edge pulse cut short");
    a_pin_polarity: assert property (irq_pin == (s.act ~^ $past(cfg.pol_high)))
        else $error("irq pin polarity wrong");
endmodule

// ===== hdl/udi_dma_irq.sv
// slave dma handshake and interrupt request logic, axi4-lite register slave
// assumes pins synchronous to CLK_SYS, one-cycle read/write strobes per beat
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`include "udi_map.svh"
module udi_dma_irq
    import udi_pkg::*;
(
    // clock and reset
    input  wire logic             CLK_SYS,
    input  wire logic             RST,
    // axi4-lite write
    input  wire logic [7:0]       S_AXI_AWADDR,
    input  wire logic             S_AXI_AWVALID,
    output logic                  S_AXI_AWREADY,
    input  wire logic [31:0]      S_AXI_WDATA,
    input  wire logic [3:0]       S_AXI_WSTRB,
    input  wire logic             S_AXI_WVALID,
    output logic                  S_AXI_WREADY,
    output logic [1:0]            S_AXI_BRESP,
    output logic                  S_AXI_BVALID,
    input  wire logic             S_AXI_BREADY,
    // axi4-lite read
    input  wire logic [7:0]       S_AXI_ARADDR,
    input  wire logic             S_AXI_ARVALID,
    output logic                  S_AXI_ARREADY,
    output logic [31:0]           S_AXI_RDATA,
    output logic [1:0]            S_AXI_RRESP,
    output logic                  S_AXI_RVALID,
    input  wire logic             S_AXI_RREADY,
    // dma pins
    output logic                  DMA_REQUEST,
    input  wire logic             DMA_GRANT,
    input  wire logic             DMA_RD,
    input  wire logic             DMA_WR,
    // memory port
    output logic [15:0]           MEM_ADDR,
    output logic                  MEM_WE,
    output logic                  MEM_RE,
    output logic [3:0]            MEM_BE,
    // descriptor done maps and interrupt
    input  wire logic [2:0][31:0] DONE_MAP,
    output logic                  IRQ
);
    udi_core_s      s;
    udi_core_s      next_s;
    udi_shape_cfg_s shp;
    logic [2:0]     wbytes;
    logic [7:0]     bcyc;
    logic           gnt;
    logic           beat;
    logic           last_xfer;
    logic           last_burst;
    logic           wr_do;
    logic           go_wr;
    logic [31:0]    wmask;
    logic [31:0]    clr;
    logic [31:0]    set;
    logic [2:0]     cond;
    logic [2:0]     rise;
    logic           atl_fire;
    logic           irq_want;
    logic           irq_pin;
    logic [3:0]     full_be;
    ////////////////////////////////////////////////////////////////////////
    // byte-lane merge for bus writes
    function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] b);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (b[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // dma helpers
    assign wbytes     = s.hw[`UDI_B_BUS32] ? 3'h4 : 3'h2;
    assign bcyc       = s.hw[`UDI_B_BUS32] ? {2'h0, s.cfg[`UDI_B_BURST+2 +: 6]}
                                           : {1'h0, s.cfg[`UDI_B_BURST+1 +: 7]};
    assign full_be    = s.hw[`UDI_B_BUS32] ? 4'hF : 4'h3;
    assign gnt        = DMA_GRANT ~^ s.hw[`UDI_B_GNTHI];
    assign beat       = gnt && (DMA_RD || DMA_WR) && s.dma != UDI_IDLE;
    assign last_xfer  = s.remain <= {14'h0, wbytes};
    assign last_burst = (bcyc <= 8'h1) || (s.bcnt == bcyc - 8'h1);
    // register write helpers
    assign wr_do = s.aw_got && s.w_got && !s.bvalid;
    assign wmask = mrg(32'h0, s.wdata, s.wstrb);
    assign go_wr = wr_do && s.awaddr == `UDI_A_CFG && wmask[`UDI_B_GO];
    ////////////////////////////////////////////////////////////////////////
    // done-map mask conditions
    genvar k;
    generate
        for (k = 0; k < 3; k++) begin : g_cat
            assign cond[k] = (|(DONE_MAP[k] & s.orm[k]))
                || (|s.andm[k] && (DONE_MAP[k] & s.andm[k]) == s.andm[k]);
        end
    endgenerate
    assign rise     = cond & ~s.cond_q;
    assign atl_fire = (s.atl_to == 16'h0) ? rise[2]
                    : (s.tmr == 16'h0 && (s.atl_pend || rise[2]));
    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s = s;
        clr    = 32'h0;
        set    = 32'h0;
        // bus channel handshakes
        if (S_AXI_AWVALID && s.awready) begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && s.wready) begin
            next_s.w_got = 1'b1;
            next_s.wdata = S_AXI_WDATA;
            next_s.wstrb = S_AXI_WSTRB;
        end
        if (s.bvalid && S_AXI_BREADY) begin
            next_s.bvalid = 1'b0;
        end
        if (s.rvalid && S_AXI_RREADY) begin
            next_s.rvalid = 1'b0;
        end
        // register writes
        if (wr_do) begin
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = `UDI_RESP_OK;
            case (s.awaddr)
                `UDI_A_HW:    next_s.hw      = mrg(s.hw, s.wdata, s.wstrb);
                `UDI_A_START: next_s.start   = mrg(s.start, s.wdata, s.wstrb);
                `UDI_A_CFG:   next_s.cfg     = mrg(s.cfg, s.wdata, s.wstrb);
                `UDI_A_LEN:   next_s.len     = mrg(s.len, s.wdata, s.wstrb);
                `UDI_A_STAT:  clr            = wmask;
                `UDI_A_IEN:   next_s.ien     = mrg(s.ien, s.wdata, s.wstrb);
                `UDI_A_EDGE:  next_s.edge_sh = mrg(s.edge_sh, s.wdata, s.wstrb);
                `UDI_A_ORM0:  next_s.orm[0]  = mrg(s.orm[0], s.wdata, s.wstrb);
                `UDI_A_ORM1:  next_s.orm[1]  = mrg(s.orm[1], s.wdata, s.wstrb);
                `UDI_A_ORM2:  next_s.orm[2]  = mrg(s.orm[2], s.wdata, s.wstrb);
                `UDI_A_ANDM0: next_s.andm[0] = mrg(s.andm[0], s.wdata, s.wstrb);
                `UDI_A_ANDM1: next_s.andm[1] = mrg(s.andm[1], s.wdata, s.wstrb);
                `UDI_A_ANDM2: next_s.andm[2] = mrg(s.andm[2], s.wdata, s.wstrb);
                `UDI_A_ATLTO: next_s.atl_to  = 16'(mrg({16'h0, s.atl_to}, s.wdata, s.wstrb));
                default:      next_s.bresp   = `UDI_RESP_ERR;
            endcase
        end
        // register reads
        if (S_AXI_ARVALID && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = `UDI_RESP_OK;
            case (S_AXI_ARADDR)
                `UDI_A_HW:    next_s.rdata = s.hw;
                `UDI_A_START: next_s.rdata = s.start;
                `UDI_A_CFG:   next_s.rdata = {s.cfg[31:2], s.dma != UDI_IDLE, s.cfg[0]};
                `UDI_A_LEN:   next_s.rdata = s.len;
                `UDI_A_STAT:  next_s.rdata = s.status;
                `UDI_A_IEN:   next_s.rdata = s.ien;
                `UDI_A_EDGE:  next_s.rdata = s.edge_sh;
                `UDI_A_ORM0:  next_s.rdata = s.orm[0];
                `UDI_A_ORM1:  next_s.rdata = s.orm[1];
                `UDI_A_ORM2:  next_s.rdata = s.orm[2];
                `UDI_A_ANDM0: next_s.rdata = s.andm[0];
                `UDI_A_ANDM1: next_s.rdata = s.andm[1];
                `UDI_A_ANDM2: next_s.rdata = s.andm[2];
                `UDI_A_ATLTO: next_s.rdata = {16'h0, s.atl_to};
                `UDI_A_CUR:   next_s.rdata = {s.addr, 15'h0, s.dma != UDI_IDLE};
                default: begin
                    next_s.rdata = 32'h0;
                    next_s.rresp = `UDI_RESP_ERR;
                end
            endcase
        end
        // dma beats; a qualified beat moves strobes, address and count; HOLD returns to REQ once grant drops
        next_s.mwe = 1'b0;
        next_s.mre = 1'b0;
        if (beat) begin
            next_s.maddr  = s.addr;
            next_s.mwe    = DMA_WR;
            next_s.mre    = DMA_RD && !DMA_WR;
            next_s.mbe    = (DMA_WR && s.remain < {14'h0, wbytes})
                          ? 4'((5'h1 << s.remain[1:0]) - 5'h1) : full_be;
            next_s.addr   = s.addr + {13'h0, wbytes};
            next_s.remain = last_xfer ? 17'h0 : 17'(s.remain - {14'h0, wbytes});
            next_s.bcnt   = s.bcnt + 8'h1;
            if (last_xfer) begin
                next_s.dma = UDI_IDLE;
                set[`UDI_B_DMADONE] = 1'b1;
            end else if (last_burst) begin
                next_s.dma  = UDI_HOLD;
                next_s.bcnt = 8'h0;
            end
        end else if (s.dma == UDI_HOLD && !gnt) begin
            next_s.dma = UDI_REQ;
        end
        // programming starts a new transfer and replaces any running one
        if (go_wr) begin
            next_s.dma    = UDI_REQ;
            next_s.addr   = s.start[15:0];
            next_s.remain = s.len[16:0];
            next_s.bcnt   = 8'h0;
        end
        next_s.req_pin = (next_s.dma == UDI_REQ) ~^ next_s.hw[`UDI_B_REQHI];
        // async-list interval timer
        next_s.cond_q = cond;
        if (s.atl_to != 16'h0) begin
            next_s.atl_pend = (s.atl_pend || rise[2]) && !atl_fire;
            next_s.tmr      = (s.tmr == 16'h0) ? s.atl_to - 16'h1 : s.tmr - 16'h1;
        end else begin
            next_s.atl_pend = 1'b0;
            next_s.tmr      = 16'h0;
        end
        // status: set wins over clear
        set[`UDI_B_CAT0 +: 3] = {atl_fire, rise[1:0]};
        next_s.status = (s.status & ~clr) | set;
        // readies from flops
        next_s.awready = !next_s.aw_got && !next_s.bvalid;
        next_s.wready  = !next_s.w_got && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;
    end
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            s         <= '0;
            s.dma     <= UDI_IDLE;
            s.edge_sh <= `UDI_EDGE_RST;
            s.req_pin <= 1'b1;
            s.awready <= 1'b1;
            s.wready  <= 1'b1;
            s.arready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // interrupt line
    assign irq_want      = s.hw[`UDI_B_GATE] && |(s.status & s.ien);
    assign shp.edge_mode = s.hw[`UDI_B_TRIG];
    assign shp.pol_high  = s.hw[`UDI_B_POL];
    assign shp.pw_field  = s.edge_sh[15:0];
    assign shp.gap_field = s.edge_sh[`UDI_B_GAP +: 8];
    udi_irq_shaper u_shape (
        .clk     (CLK_SYS),
        .rst     (RST),
        .cfg     (shp),
        .want    (irq_want),
        .irq_pin (irq_pin)
    );
    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign S_AXI_AWREADY = s.awready;
    assign S_AXI_WREADY  = s.wready;
    assign S_AXI_BVALID  = s.bvalid;
    assign S_AXI_BRESP   = s.bresp;
    assign S_AXI_ARREADY = s.arready;
    assign S_AXI_RVALID  = s.rvalid;
    assign S_AXI_RDATA   = s.rdata;
    assign S_AXI_RRESP   = s.rresp;
    assign DMA_REQUEST   = s.req_pin;
    assign MEM_ADDR      = s.maddr;
    assign MEM_WE        = s.mwe;
    assign MEM_RE        = s.mre;
    assign MEM_BE        = s.mbe;
    assign IRQ           = irq_pin;
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    sequence s_final_beat;
        beat && !go_wr && (last_xfer || last_burst);
    endsequence
    sequence s_done_beat;
        beat && !go_wr && last_xfer;
    endsequence
    a_go_raises: assert property (go_wr |=> s.dma == UDI_REQ)
        else $error("go did not raise request");
    a_drop_on_final: assert property (s_final_beat |=> s.dma != UDI_REQ)
        else $error("request not dropped on final strobe");
    a_done_sets_flag: assert property (s_done_beat |=> s.status[`UDI_B_DMADONE] && s.dma == UDI_IDLE)
        else $error("done flag missing");
    a_idle_stays: assert property (s.dma == UDI_IDLE && !go_wr |=> s.dma == UDI_IDLE)
        else $error("request rose without programming");
    a_no_move_idle: assert property (!beat && !go_wr |=> $stable(s.addr) && $stable(s.remain))
        else $error("count or address moved without beat");
    a_addr_step: assert property (beat && !go_wr |=> s.addr == 16'($past(s.addr) + {13'h0, $past(wbytes)}))
        else $error("address did not step by width");
    a_req_pin: assert property (DMA_REQUEST == (($past(next_s.dma) == UDI_REQ) ~^ s.hw[`UDI_B_REQHI]))
        else $error("request pin polarity wrong");
    a_set_wins: assert property (set[`UDI_B_DMADONE] && clr[`UDI_B_DMADONE] |=> s.status[`UDI_B_DMADONE])
        else $error("clear beat a new event");
    a_rehold_release: assert property (s.dma == UDI_HOLD && !gnt && !beat && !go_wr |=> s.dma == UDI_REQ)
        else $error("request not re-raised after release");
endmodule

// ===== dv/udi_dma_ctl.sv
// partner model: system dma controller answering the request pin
// assumes low-true request and grant, strobes sampled on rising clk
module udi_dma_ctl (
    // clock
    input  wire logic clk,
    // dma pins
    input  wire logic req,
    input  wire logic rd_dir,
    output logic      gnt,
    output logic      rd,
    output logic      wr,
    // beat tally
    output int        beats
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        gnt = 1'b1;
        rd = 1'b0;
        wr = 1'b0;
        beats = 0;
        forever begin
            @(posedge clk);
            if (req === 1'b0) begin
                gnt <= 1'b0;
                do begin
                    @(posedge clk);
                    rd <= rd_dir;
                    wr <= !rd_dir;
                    @(posedge clk);
                    rd <= 1'b0;
                    wr <= 1'b0;
                    beats++;
                    #1;
                end while (req === 1'b0);
                @(posedge clk);
                gnt <= 1'b1;
            end
        end
    end
endmodule

// ===== dv/udi_dma_irq_tb.sv
// testbench: axi4-lite master, random dma transfers, irq checks
// assumes udi_dma_ctl as far side, low-true pins after reset
module udi_dma_irq_tb
    import udi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic             clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0, dir = 1'b0;
    logic [7:0]       awa = 8'h00, ara = 8'h00;
    logic [31:0]      wd = 32'h0, rd, x, seed = 32'hB21D;
    logic [2:0][31:0] dmap = '0;
    logic [1:0]       rr, r, br, bq;
    logic             awr, wrdy, bv, arr, rv, req, gnt, srd, swr, irq, mw, mr;
    logic [15:0]      ma, la;
    logic [3:0]       mb, lb;
    int               fail_count = 0, total_checks = 0, beats, n, nm = 0;
    int               cycs[4] = '{1, 4, 8, 16};
    udi_dma_irq dut_u (
        .CLK_SYS(clk), .RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
        .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(ara),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(1'b1), .DMA_REQUEST(req), .DMA_GRANT(gnt),
        .DMA_RD(srd), .DMA_WR(swr), .MEM_ADDR(ma), .MEM_WE(mw), .MEM_RE(mr), .MEM_BE(mb),
        .DONE_MAP(dmap), .IRQ(irq)
    );
    udi_dma_ctl far_u (.clk(clk), .req(req), .rd_dir(dir), .gnt(gnt), .rd(srd), .wr(swr), .beats(beats));
    always #50 clk = ~clk;
    // memory port monitor: last beat's address and lanes, pulse tally
    always @(negedge clk) begin
        if (mw || mr) begin
            la <= ma;
            lb <= mb;
            nm <= nm + 1;
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic err(input string m);
        fail_count++;
        $display("MISMATCH %0t %s", $time, m);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        total_checks++;
        if (g !== e) err(m);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int exp_beats(int len, int w);
        return (len + w - 1) / w;
    endfunction
    function automatic logic [3:0] exp_be(int len, int w, logic rdd);
        if (!rdd && len % w != 0) return 4'((1 << (len % w)) - 1);
        return (w == 4) ? 4'hF : 4'h3;
    endfunction
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic ka, kw, kb;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        for (int i = 0; i < 64; i++) begin
            @(negedge clk);
            ka = awr & awv;
            kw = wrdy & wv;
            kb = bv;
            bq = br;
            @(posedge clk);
            if (ka) awv <= 1'b0;
            if (kw) wv <= 1'b0;
            if (kb) return;
        end
        err("write hang");
        summarize();
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] e);
        logic ka, kr;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        for (int i = 0; i < 64; i++) begin
            @(negedge clk);
            ka = arr & arv;
            kr = rv;
            d = rd;
            e = rr;
            @(posedge clk);
            if (ka) arv <= 1'b0;
            if (kr) return;
        end
        err("read hang");
        summarize();
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] k, input logic [31:0] e, input string m);
        axr(a, x, r);
        chk(x & k, e, m);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic xfer(input logic b, input int len, input int cy, input logic [31:0] ie);
        int b0, w, m0, nb;
        logic [31:0] d;
        w = b ? 4 : 2;
        b0 = beats;
        m0 = nm;
        nb = exp_beats(len, w);
        d = rnd();
        dir <= d[0];
        axw(8'h14, ie);
        axw(8'h00, {23'h0, b, 8'h01});
        axw(8'h04, 32'h100);
        axw(8'h0C, len);
        axw(8'h08, {16'h0, 8'(cy * w), 6'h0, 1'b1, d[0]});
        d = 32'h0;
        for (int i = 0; i < 300 && d[3] !== 1'b1; i++) axr(8'h10, d, r);
        chk(d[3], 1, "done flag");
        if (d[3] !== 1'b1) summarize();
        chk(beats - b0, nb, "beat count");
        chk(nm - m0, nb, "memory strobes");
        chk(la, 32'h100 + (nb - 1) * w, "last beat address");
        chk(lb, exp_be(len, w, dir), "last beat lanes");
        rchk(8'h40, 32'hFFFF0001, (32'h100 + nb * w) << 16, "current address");
        repeat (6) @(negedge clk);
        chk(req, 1, "request after end");
        chk(irq, !ie[3], "irq level");
        axw(8'h10, d);
        repeat (2) @(negedge clk);
        chk(irq, 1, "irq after clear");
        rchk(8'h10, 32'hFFFFFFFF, 0, "status clear");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rchk(8'h18, 32'hFFFFFFFF, 32'h20, "shaping reset");
        rchk(8'h00, 32'hFFFFFFFF, 0, "mode reset");
        chk(irq, 1, "irq idle");
        axr(8'h7C, x, r);
        chk(r, 2'b10, "unmapped");
        axw(8'h7C, 32'h0);
        chk(bq, 2'b10, "unmapped write");
        xfer(1'b1, 8, 4, 0);
        xfer(1'b0, 7, 1, 8);
        for (int i = 0; i < 6; i++) begin
            x = rnd();
            xfer(x[0], x[7:2] + 1, cycs[x[9:8]], {28'h0, x[10], 3'h0});
        end
        axw(8'h34, 32'h14);
        dmap[1][2] <= 1'b1;
        rchk(8'h10, 32'h100, 0, "and partial");
        dmap[1][4] <= 1'b1;
        rchk(8'h10, 32'h100, 32'h100, "and full");
        axw(8'h10, 32'hFFFFFFFF);
        axw(8'h14, 32'h80);
        axw(8'h20, 32'h1);
        axw(8'h00, 32'h7);
        dmap[0][0] <= 1'b1;
        n = 0;
        fork
            repeat (40) begin
                @(negedge clk);
                if (irq === 1'b1) n++;
            end
            axw(8'h10, 32'hFFFFFFFF);
        join
        chk(n, 5, "edge pulse width");
        axw(8'h00, 32'h20);
        repeat (2) @(negedge clk);
        chk(req, 0, "request polarity");
        n = nm;
        repeat (10) @(negedge clk);
        chk(nm, n, "strobes while idle");
        summarize();
    end
endmodule
